// ==== src/gdc_regs.svh ====
`ifndef GDC_REGS_SVH
`define GDC_REGS_SVH

`define GDC_CLK_PERIOD_NS 20
`define GDC_FAULT_MUTE_NS 10000
`define GDC_RST_PULSE_NS 1000
`define GDC_DEGLITCH_NS 40
`define GDC_CNT_W 16
`define GDC_MUTE_CYC \
	((`GDC_FAULT_MUTE_NS + `GDC_CLK_PERIOD_NS - 1) / `GDC_CLK_PERIOD_NS)
`define GDC_PULSE_CYC \
	((`GDC_RST_PULSE_NS + `GDC_CLK_PERIOD_NS - 1) / `GDC_CLK_PERIOD_NS)
`define GDC_DEGLITCH_CYC \
	((`GDC_DEGLITCH_NS + `GDC_CLK_PERIOD_NS - 1) / `GDC_CLK_PERIOD_NS)

`endif

// ==== src/gdc_pkg.sv ====
package gdc_pkg;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_MUTE,
		SEQ_WAIT,
		SEQ_PULSE
	} gdc_seq_state_type;

endpackage: gdc_pkg

// ==== src/gdc_seq_if.sv ====
`timescale 1ns/100ps

interface gdc_seq_if;
	logic fault_low;
	logic clear_req;
	logic auto_mode;
	logic mute;
	logic pulse;
	logic busy;

	modport ctrl (
		output fault_low,
		output clear_req,
		output auto_mode,
		input mute,
		input pulse,
		input busy
	);

	modport seq (
		input fault_low,
		input clear_req,
		input auto_mode,
		output mute,
		output pulse,
		output busy
	);
endinterface: gdc_seq_if

// ==== src/gdc_reset_seq.sv ====
`timescale 1ns/100ps
`include "gdc_regs.svh"

module gdc_reset_seq
	import gdc_pkg::*;
#(
	parameter logic [`GDC_CNT_W-1:0] MUTE_CYC = `GDC_CNT_W'(`GDC_MUTE_CYC),
	parameter logic [`GDC_CNT_W-1:0] PULSE_CYC = `GDC_CNT_W'(`GDC_PULSE_CYC)
) (
	input wire logic clk, // System clock
	input wire logic rst_b, // Async reset, active low
	input wire logic ce, // Clock enable, freezes state when low
	gdc_seq_if.seq sif // Sequencer side of the control link
);
	gdc_seq_state_type state_reg;
	gdc_seq_state_type state_next;
	logic [`GDC_CNT_W-1:0] cnt_reg;
	logic last_mute;
	logic last_pulse;

	assign last_mute = cnt_reg == MUTE_CYC - `GDC_CNT_W'(1);
	assign last_pulse = cnt_reg == PULSE_CYC - `GDC_CNT_W'(1);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			SEQ_IDLE: begin
				if (sif.fault_low)
					state_next = SEQ_MUTE;
			end
			SEQ_MUTE: begin
				// Any reset now is ignored by the driver, so wait it out
				if (last_mute)
					state_next = SEQ_WAIT;
			end
			SEQ_WAIT: begin
				if (!sif.fault_low)
					state_next = SEQ_IDLE;
				else if (sif.clear_req && !sif.auto_mode)
					state_next = SEQ_PULSE;
			end
			SEQ_PULSE: begin
				// Back to wait: the flag rises only after the pulse ends
				if (last_pulse)
					state_next = SEQ_WAIT;
			end
			default: state_next = SEQ_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			state_reg <= SEQ_IDLE;
		else if (ce)
			state_reg <= state_next;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			cnt_reg <= '0;
		else if (ce) begin
			if (state_next != state_reg)
				cnt_reg <= '0;
			else if (state_reg == SEQ_MUTE || state_reg == SEQ_PULSE)
				cnt_reg <= cnt_reg + `GDC_CNT_W'(1);
		end
	end

	assign sif.mute = state_reg == SEQ_MUTE;
	assign sif.pulse = state_reg == SEQ_PULSE;
	assign sif.busy = state_reg != SEQ_IDLE;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence fault_seen_idle;
		ce && state_reg == SEQ_IDLE && sif.fault_low;
	endsequence

	sequence pulse_begins;
		ce && state_reg == SEQ_WAIT && state_next == SEQ_PULSE;
	endsequence

	chk_mute_starts: assert property (
		fault_seen_idle |=> sif.mute [*8])
		else $error("mute did not start or was cut short");

	chk_mute_holds: assert property (
		(ce && sif.mute && !last_mute) |=> sif.mute)
		else $error("mute ended before its full count");

	chk_pulse_width: assert property (
		pulse_begins |=> sif.pulse [*8])
		else $error("reset pulse shorter than required");

	chk_pulse_after_mute: assert property (
		$rose(sif.pulse) |-> $past(state_reg) == SEQ_WAIT)
		else $error("reset pulse did not follow the mute wait");

endmodule: gdc_reset_seq

// ==== src/gdc_ctrl.sv ====
`timescale 1ns/100ps
`include "gdc_regs.svh"

module gdc_ctrl
	import gdc_pkg::*;
#(
	parameter logic [`GDC_CNT_W-1:0] MUTE_CYC = `GDC_CNT_W'(`GDC_MUTE_CYC)
) (
	input wire logic clk, // System clock, 50 MHz
	input wire logic rst_b, // Async reset, active low
	input wire logic ce, // Clock enable, freezes state when low
	input wire logic pwm_req, // PWM for this switch
	input wire logic pwm_opp, // PWM of the opposite switch in the leg
	input wire logic drv_enable, // Request driver enabled
	input wire logic interlock_en, // Route opposite PWM to inverting input
	input wire logic auto_reset_en, // Drive reset/enable from PWM
	input wire logic fault_clear_req, // Request a fault reset pulse
	input wire logic fault_flag_n, // Driver fault flag, low on fault
	input wire logic power_good, // Driver power-good, low in lockout
	output logic drv_in_pos, // To driver noninverting input
	output logic drv_in_neg, // To driver inverting input
	output logic drv_rst_en_n, // To driver reset/enable, low resets
	output logic fault_active, // Fault flag seen low
	output logic supply_ok, // Power-good seen high
	output logic reset_busy, // Fault recovery in progress
	output logic mute_active // Fault mute wait running
);
	logic fault_low_reg;
	logic pg_reg;
	logic in_pos_reg;
	logic in_pos_next;
	logic in_neg_reg;
	logic in_neg_next;
	logic rst_en_n_reg;
	logic rst_en_n_next;
	logic fault_active_reg;
	logic supply_ok_reg;
	logic reset_busy_reg;
	logic mute_active_reg;

	gdc_seq_if sif ();

	// Pins are taken as synchronous; one stage aligns them to our edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fault_low_reg <= 1'b0;
			pg_reg <= 1'b0;
		end else if (ce) begin
			fault_low_reg <= !fault_flag_n;
			pg_reg <= power_good;
		end
	end

	assign sif.fault_low = fault_low_reg;
	assign sif.clear_req = fault_clear_req;
	assign sif.auto_mode = auto_reset_en;

	gdc_reset_seq #(
		.MUTE_CYC(MUTE_CYC),
		.PULSE_CYC(`GDC_CNT_W'(`GDC_PULSE_CYC))
	) u_seq (
		.clk(clk),
		.rst_b(rst_b),
		.ce(ce),
		.sif(sif)
	);

	// The driver already refuses overlapping inputs; we avoid asking it
	always_comb begin
		in_pos_next = drv_enable && pwm_req;
		if (interlock_en && pwm_opp)
			in_pos_next = 1'b0;
	end

	always_comb begin
		if (interlock_en)
			in_neg_next = pwm_opp;
		else
			in_neg_next = 1'b0;
	end

	// Mute has priority: even a disable is a reset request to the driver,
	// and it would be thrown away, so the pin is held high until mute ends
	always_comb begin
		if (sif.mute)
			rst_en_n_next = 1'b1;
		else if (!drv_enable)
			rst_en_n_next = 1'b0;
		else if (sif.pulse)
			rst_en_n_next = 1'b0;
		else if (auto_reset_en)
			rst_en_n_next = pwm_req;
		else
			rst_en_n_next = 1'b1;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			in_pos_reg <= 1'b0;
			in_neg_reg <= 1'b0;
		end else if (ce) begin
			in_pos_reg <= in_pos_next;
			in_neg_reg <= in_neg_next;
		end
	end

	// Out of reset the driver stays disabled, as with a floating pin
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			rst_en_n_reg <= 1'b0;
		else if (ce)
			rst_en_n_reg <= rst_en_n_next;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fault_active_reg <= 1'b0;
			supply_ok_reg <= 1'b0;
			reset_busy_reg <= 1'b0;
			mute_active_reg <= 1'b0;
		end else if (ce) begin
			fault_active_reg <= fault_low_reg;
			supply_ok_reg <= pg_reg;
			reset_busy_reg <= sif.busy;
			mute_active_reg <= sif.mute;
		end
	end

	assign drv_in_pos = in_pos_reg;
	assign drv_in_neg = in_neg_reg;
	assign drv_rst_en_n = rst_en_n_reg;
	assign fault_active = fault_active_reg;
	assign supply_ok = supply_ok_reg;
	assign reset_busy = reset_busy_reg;
	assign mute_active = mute_active_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence auto_active;
		ce && auto_reset_en && drv_enable && !sif.mute && !sif.pulse;
	endsequence

	chk_no_reset_mute: assert property (
		(ce && sif.mute) |=> drv_rst_en_n)
		else $error("reset/enable driven low during fault mute");

	chk_pulse_low: assert property (
		(ce && sif.pulse && drv_enable) |=> !drv_rst_en_n)
		else $error("reset pulse not driven on the pin");

	chk_neg_tied_low: assert property (
		(ce && !interlock_en) |=> !drv_in_neg)
		else $error("inverting input not held low");

	chk_neg_follows: assert property (
		(ce && interlock_en) |=> drv_in_neg == $past(pwm_opp))
		else $error("inverting input does not follow opposite PWM");

	chk_auto_follow: assert property (
		auto_active |=> drv_rst_en_n == $past(pwm_req))
		else $error("reset/enable does not follow PWM in auto mode");

	chk_no_overlap: assert property (
		(ce && interlock_en && pwm_opp) |=> !drv_in_pos && drv_in_neg)
		else $error("both driver inputs high together");

	chk_disable_low: assert property (
		(ce && !drv_enable && !sif.mute) |=> !drv_rst_en_n && !drv_in_pos)
		else $error("disable not shown on the driver pins");

	sequence flag_low_seen;
		(ce && !fault_flag_n) ##1 ce;
	endsequence

	sequence lockout_seen;
		(ce && !power_good) ##1 ce;
	endsequence

	chk_fault_status: assert property (
		flag_low_seen |=> fault_active)
		else $error("fault flag low not reported");

	chk_supply_status: assert property (
		lockout_seen |=> !supply_ok)
		else $error("supply lockout not reported");

	chk_pos_follows: assert property (
		(ce && drv_enable && !(interlock_en && pwm_opp))
		|=> drv_in_pos == $past(pwm_req))
		else $error("noninverting input does not follow PWM");

	chk_freeze_pins: assert property (
		!ce |=> $stable(drv_in_pos) && $stable(drv_in_neg)
		&& $stable(drv_rst_en_n))
		else $error("driver pins changed while clock enable low");

	chk_busy_in_mute: assert property (
		(ce && sif.mute) |=> reset_busy && mute_active)
		else $error("mute not reported as busy");

	chk_auto_no_pulse: assert property (
		(ce && auto_reset_en && !sif.pulse) |=> !sif.pulse)
		else $error("reset pulse started in auto recovery mode");

	chk_pin_high_idle: assert property (
		(ce && drv_enable && !auto_reset_en && !sif.pulse)
		|=> drv_rst_en_n)
		else $error("reset/enable low without a reset pulse");

endmodule: gdc_ctrl

// ==== test/gdc_drv_model.sv ====
`timescale 1ns/100ps

module gdc_drv_model #(
	parameter int MUTE_CYC = 10
) (
	input wire logic clk, // Filter sampling clock
	input wire logic in_pos, // Noninverting PWM
	input wire logic in_neg, // Inverting PWM
	input wire logic rst_en_n, // Reset/enable, active low
	input wire logic oc_event, // Overcurrent sensed
	input wire logic lockout, // Supply in lockout
	input wire logic force_on_in, // Forced turn-on request
	output logic clamp_fet_drive, // External clamp transistor drive
	output logic soft_off, // Fault turn-off on the soft path
	output logic fault_flag_n, // Open-drain flag with pull-up
	output logic power_good, // Open-drain power-good with pull-up
	output logic gate_on // Gate output state
);
	int mute_cnt = 0;
	int low_cnt = 0;
	logic fault_reg = 1'b0;

	// Lows inside the mute window never add up to a reset
	always @(posedge clk) begin
		low_cnt <= (rst_en_n || mute_cnt > 0) ? 0 : low_cnt + 1;
		if (mute_cnt > 0)
			mute_cnt <= mute_cnt - 1;
		if (oc_event && gate_on) begin
			fault_reg <= 1'b1;
			mute_cnt <= MUTE_CYC;
		end else if (rst_en_n && low_cnt > 2) begin
			fault_reg <= 1'b0;
		end
	end

	assign gate_on = force_on_in
		|| (in_pos && !in_neg && rst_en_n && !fault_reg
		&& !lockout);
	// Gate rests near the negative rail whenever it is not driven on
	assign clamp_fet_drive = !gate_on;
	assign soft_off = fault_reg;
	assign fault_flag_n = fault_reg ? 1'b0 : 1'b1;
	assign power_good = lockout ? 1'b0 : 1'b1;
endmodule: gdc_drv_model

// ==== test/test_gdc_ctrl.sv ====
`timescale 1ns/100ps

module test_gdc_ctrl;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1;
	logic pwm_req = 1'b1;
	logic pwm_opp = 1'b0;
	logic drv_enable = 1'b1;
	logic interlock_en = 1'b0;
	logic auto_reset_en = 1'b0;
	logic fault_clear_req = 1'b0;
	logic oc_event = 1'b0;
	logic lockout = 1'b0;
	logic force_on_in = 1'b0;
	logic clamp_fet_drive, soft_off;
	logic fault_flag_n, power_good, gate_on, drv_in_pos, drv_in_neg;
	logic drv_rst_en_n, fault_active, supply_ok, reset_busy, mute_active;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;

	always #10 clk = ~clk;

	gdc_ctrl #(.MUTE_CYC(16'h000a)) dut (.clk(clk), .rst_b(rst_b), .ce(ce),
		.pwm_req(pwm_req), .pwm_opp(pwm_opp), .drv_enable(drv_enable),
		.interlock_en(interlock_en), .auto_reset_en(auto_reset_en),
		.fault_clear_req(fault_clear_req), .fault_flag_n(fault_flag_n),
		.power_good(power_good), .drv_in_pos(drv_in_pos),
		.drv_in_neg(drv_in_neg), .drv_rst_en_n(drv_rst_en_n),
		.fault_active(fault_active), .supply_ok(supply_ok),
		.reset_busy(reset_busy), .mute_active(mute_active));

	gdc_drv_model #(.MUTE_CYC(10)) drv (.clk(clk), .in_pos(drv_in_pos),
		.in_neg(drv_in_neg), .rst_en_n(drv_rst_en_n), .oc_event(oc_event),
		.lockout(lockout), .fault_flag_n(fault_flag_n),
		.power_good(power_good), .gate_on(gate_on),
		.force_on_in(force_on_in), .clamp_fet_drive(clamp_fet_drive),
		.soft_off(soft_off));

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask: step

	task automatic chk(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask: chk

	task automatic print_verdict;
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask: print_verdict

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			print_verdict();
		end
	end

	task automatic test_pins;
		step(5);
		chk("drv_rst_en_n", 1'b0, drv_rst_en_n);
		rst_b = 1'b1;
		step(2);
		chk("gate_on", 1'b1, gate_on);
		chk("drv_in_pos", 1'b1, drv_in_pos);
		drv_enable = 1'b0;
		step(1);
		chk("gate_on", 1'b0, gate_on);
		drv_enable = 1'b1;
		ce = 1'b0;
		pwm_req = 1'b0;
		step(2);
		chk("drv_rst_en_n", 1'b0, drv_rst_en_n);
		ce = 1'b1;
		pwm_req = 1'b1;
		interlock_en = 1'b1;
		pwm_opp = 1'b1;
		step(1);
		chk("drv_in_neg", 1'b1, drv_in_neg);
		chk("gate_on", 1'b0, gate_on);
		chk("drv_in_pos", 1'b0, drv_in_pos);
		interlock_en = 1'b0;
		lockout = 1'b1;
		step(3);
		chk("drv_in_neg", 1'b0, drv_in_neg);
		chk("supply_ok", 1'b0, supply_ok);
		chk("gate_on", 1'b0, gate_on);
		chk("clamp_fet_drive", 1'b1, clamp_fet_drive);
		force_on_in = 1'b1;
		step(1);
		chk("gate_on", 1'b1, gate_on);
		force_on_in = 1'b0;
		lockout = 1'b0;
		step(3);
		chk("supply_ok", 1'b1, supply_ok);
		chk("gate_on", 1'b1, gate_on);
		$display("end pins");
	endtask: test_pins

	task automatic test_fault;
		oc_event = 1'b1;
		step(1);
		oc_event = 1'b0;
		chk("gate_on", 1'b0, gate_on);
		chk("soft_off", 1'b1, soft_off);
		step(3);
		chk("fault_active", 1'b1, fault_active);
		chk("mute_active", 1'b1, mute_active);
		chk("reset_busy", 1'b1, reset_busy);
		drv_enable = 1'b0;
		fault_clear_req = 1'b1;
		step(2);
		chk("drv_rst_en_n", 1'b1, drv_rst_en_n);
		chk("fault_flag_n", 1'b0, fault_flag_n);
		drv_enable = 1'b1;
		for (int i = 0; i < 200 && reset_busy !== 1'b0; i++)
			step(1);
		fault_clear_req = 1'b0;
		chk("reset_busy", 1'b0, reset_busy);
		chk("fault_active", 1'b0, fault_active);
		chk("gate_on", 1'b1, gate_on);
		$display("end fault");
	endtask: test_fault

	task automatic test_auto;
		auto_reset_en = 1'b1;
		oc_event = 1'b1;
		step(1);
		oc_event = 1'b0;
		pwm_req = 1'b0;
		step(3);
		chk("drv_rst_en_n", 1'b1, drv_rst_en_n);
		step(16);
		chk("drv_rst_en_n", 1'b0, drv_rst_en_n);
		chk("fault_flag_n", 1'b0, fault_flag_n);
		pwm_req = 1'b1;
		step(4);
		chk("fault_flag_n", 1'b1, fault_flag_n);
		chk("gate_on", 1'b1, gate_on);
		$display("end auto");
	endtask: test_auto

	initial begin
		test_pins();
		test_fault();
		test_auto();
		print_verdict();
	end
endmodule: test_gdc_ctrl
